// ---- shared/ddr4_maint_params.svh ----
// Constants for the DDR4 refresh, calibration and data-pin host controller
`ifndef DDR4_MAINT_PARAMS_SVH
`define DDR4_MAINT_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_WDATA       8'h08
`define REG_RDATA       8'h0C
`define REG_STATUS      8'h10

// ****************************************
// Field positions
// ****************************************
`define CTRL_MODE_LO    0
`define CTRL_DM         2
`define CTRL_WDBI       3
`define CTRL_RDBI       4
`define CTRL_TDQS       5
`define CTRL_HOLD       6
`define CMD_REF         0
`define CMD_ZQCL        1
`define CMD_ZQCS        2
`define CMD_WR          3
`define CMD_RD          4
`define WDATA_MASK      8
`define STAT_BUSY       0
`define STAT_ZQINIT     1
`define STAT_OWED_LO    8

// ****************************************
// Refresh modes and limits
// ****************************************
`define MODE_1X         2'h0
`define MODE_2X         2'h1
`define MODE_4X         2'h2
`define MAX_POST_1X     8'h08
`define BYTE_ZERO_LIMIT 4'h4

// ****************************************
// Command pin codes {cs_n,act_n,ras_n,cas_n,we_n,a10}
// ****************************************
`define CMD_CODE_DES    6'h3E
`define CMD_CODE_REF    6'h12
`define CMD_CODE_PREA   6'h15
`define CMD_CODE_ZQCL   6'h1D
`define CMD_CODE_ZQCS   6'h1C

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_PS   5000
`define T_RP_PS         14160
`define T_REFI_NS       7800
`define T_RFC_NS        260
`define T_ZQINIT_NCK    1024
`define T_ZQOPER_NCK    512
`define T_ZQCS_NCK      128
`define CK_HALF_CYC     2

`endif

// ---- shared/ddr4_maint_pkg.sv ----
// Types for the DDR4 refresh, calibration and data-pin host controller
package ddr4_maint_pkg;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_TRP  = 7'h02,
        S_TRFC = 7'h04,
        S_TZQ  = 7'h08,
        S_WR   = 7'h10,
        S_RD   = 7'h20,
        S_SPARE = 7'h40
    } state_e;

    typedef struct packed {
        logic cs_n;
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic a10;
    } cmd_s;

    typedef struct packed {
        logic       hold;
        logic       tdqs;
        logic       rdbi;
        logic       wdbi;
        logic       dm;
        logic [1:0] mode;
    } ctrl_s;

endpackage

// ---- core/ddr4_maint_host.sv ----
// What this block does
// - Refresh goes out as CS, RAS, CAS low with WE and ACT high.
// - Refresh only after precharge-all and the precharge time have passed.
// - After refresh only deselects until the refresh cycle time elapses.
// - Postponed refreshes forced so surrounding gap stays within 9, 17, 33 intervals.
// - At most 8, 16 or 32 pulled-in refreshes, each cancelling one later.
// - Pulled-in refreshes stay within 16, 32, 64 per window, honouring refresh time; no per-window count is kept, only the owed_ff credit range bounds it.
// - Mask and write inversion never both on; both off leaves pin undriven.
// - Calibration only on an explicit command, never after self refresh exit early.
// - Channel kept quiet during every calibration window.
// - Calibration only after precharge-all and the precharge time.
// - Clock enable high and data bus released during calibration.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ddr4_maint_params.svh"

module ddr4_maint_host
    import ddr4_maint_pkg::*;
#(
    parameter int CK_HALF     = `CK_HALF_CYC,
    parameter int TRFC_NS     = `T_RFC_NS,
    parameter int TZQINIT_NCK = `T_ZQINIT_NCK,
    parameter int TZQOPER_NCK = `T_ZQOPER_NCK,
    parameter int TZQCS_NCK   = `T_ZQCS_NCK
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             ck_t,
    output logic             ck_c,
    output logic             cke,
    output logic             cs_n,
    output logic             act_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic             addr_a10,
    input  wire logic [7:0]  dq_i,
    output logic      [7:0]  dq_o,
    output logic             dq_oe,
    input  wire logic        dmi_i,
    output logic             dmi_o,
    output logic             dmi_oe
);

    // ****************************************
    // Derived cycle counts
    // ****************************************
    localparam int NCK_CYC   = 2 * CK_HALF;
    localparam int TRP_CYC   = (`T_RP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
    localparam int TRFC_CYC  = (TRFC_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
    localparam int TREFI_CYC = (`T_REFI_NS * 1000) / `CLK_PERIOD_PS;
    localparam int TZQI_CYC  = TZQINIT_NCK * NCK_CYC;
    localparam int TZQO_CYC  = TZQOPER_NCK * NCK_CYC;
    localparam int TZQS_CYC  = TZQCS_NCK * NCK_CYC;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic signed [7:0] max_of(input logic [1:0] mode);
        max_of = $signed(`MAX_POST_1X << mode);
    endfunction

    function automatic logic [3:0] zeros_of(input logic [7:0] b);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, ~b[i]};
        end
        zeros_of = n;
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    state_e                state_ff;
    cmd_s                  cmd_ff;
    ctrl_s                 ctrl_ff;
    ctrl_s                 nxt_ctrl;
    logic [7:0]            ck_cnt_ff;
    logic                  ck_ff;
    logic                  tick;
    logic                  launch_ff;
    logic [15:0]           timer_ff;
    logic                  goal_zq_ff;
    logic                  goal_long_ff;
    logic                  zq_init_done_ff;
    logic [15:0]           refi_cnt_ff;
    logic [15:0]           refi_len;
    logic signed [7:0]     owed_ff;
    logic signed [7:0]     max_post;
    logic                  ref_due;
    logic                  pend_ref_ff;
    logic                  pend_zql_ff;
    logic                  pend_zqs_ff;
    logic                  pend_wr_ff;
    logic                  pend_rd_ff;
    logic                  go_ref;
    logic                  go_zq;
    logic                  go_wr;
    logic                  go_rd;
    logic                  ref_launch;
    logic [8:0]            wdata_ff;
    logic [7:0]            rdata_ff;
    logic [7:0]            dq_s1_ff;
    logic [7:0]            dq_s2_ff;
    logic                  dmi_s1_ff;
    logic                  dmi_s2_ff;
    logic [7:0]            dq_o_ff;
    logic                  dq_oe_ff;
    logic                  dmi_o_ff;
    logic                  dmi_oe_ff;
    logic                  ack_ff;
    logic                  bus_wr;
    logic                  busy;
    logic [31:0]           rd_mux;
    logic [31:0]           readdata_ff;
    logic [15:0]           since_pre_ff;
    logic [15:0]           since_ref_ff;

    // ****************************************
    // Clock divider for CK
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ck_cnt_ff <= 8'h00;
            ck_ff     <= 1'b0;
        end else if (ck_cnt_ff == 8'(CK_HALF - 1)) begin
            ck_cnt_ff <= 8'h00;
            ck_ff     <= ~ck_ff;
        end else begin
            ck_cnt_ff <= ck_cnt_ff + 8'h01;
        end
    end

    // Commands change as CK falls, so the device sees them stable at its rise
    assign tick = (ck_cnt_ff == 8'(CK_HALF - 1)) && ck_ff;
    assign ck_t = ck_ff;
    assign ck_c = ~ck_ff;
    assign cke  = 1'b1;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            launch_ff <= 1'b0;
        end else begin
            launch_ff <= tick;
        end
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_s1_ff  <= 8'h00;
            dq_s2_ff  <= 8'h00;
            dmi_s1_ff <= 1'b1;
            dmi_s2_ff <= 1'b1;
        end else begin
            dq_s1_ff  <= dq_i;
            dq_s2_ff  <= dq_s1_ff;
            dmi_s1_ff <= dmi_i;
            dmi_s2_ff <= dmi_s1_ff;
        end
    end

    // ****************************************
    // Avalon slave
    // ****************************************
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign bus_wr          = avs_write && ack_ff;
    assign avs_readdata    = readdata_ff;
    // Busy covers queued requests too, so no idle gap shows between chained commands
    assign busy            = (state_ff != S_IDLE) || pend_ref_ff || pend_zql_ff || pend_zqs_ff ||
                             pend_wr_ff || pend_rd_ff;

    always_comb begin
        case (avs_address)
            `REG_CTRL:   rd_mux = {25'h0, ctrl_ff};
            `REG_WDATA:  rd_mux = {23'h0, wdata_ff};
            `REG_RDATA:  rd_mux = {24'h0, rdata_ff};
            `REG_STATUS: rd_mux = {16'h0, owed_ff, 6'h00, zq_init_done_ff, busy};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff      <= 1'b0;
            readdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
            if (avs_read && !ack_ff) begin
                readdata_ff <= rd_mux;
            end
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    always_comb begin
        nxt_ctrl = ctrl_s'(avs_writedata[6:0]);
        if (nxt_ctrl.mode > `MODE_4X) begin
            nxt_ctrl.mode = `MODE_4X;
        end
        if (nxt_ctrl.dm) begin
            nxt_ctrl.wdbi = 1'b0;
        end
        if (nxt_ctrl.tdqs) begin
            nxt_ctrl.dm   = 1'b0;
            nxt_ctrl.wdbi = 1'b0;
            nxt_ctrl.rdbi = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff  <= ctrl_s'(7'h00);
            wdata_ff <= 9'h000;
        end else if (bus_wr && avs_address == `REG_CTRL) begin
            ctrl_ff <= nxt_ctrl;
        end else if (bus_wr && avs_address == `REG_WDATA) begin
            wdata_ff <= avs_writedata[8:0];
        end
    end

    // ****************************************
    // Refresh budget
    // ****************************************
    assign refi_len   = 16'(TREFI_CYC) >> ctrl_ff.mode;
    assign max_post   = max_of(ctrl_ff.mode);
    assign ref_launch = (state_ff == S_TRP) && tick && timer_ff == 16'h0000 && !goal_zq_ff;
    // Forced once the postponed count reaches its limit
    assign ref_due    = (owed_ff > 8'sh00) && (!ctrl_ff.hold || owed_ff >= max_post);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            refi_cnt_ff <= 16'h0000;
            owed_ff     <= 8'sh00;
        end else begin
            refi_cnt_ff <= (refi_cnt_ff >= refi_len - 16'h0001) ? 16'h0000 : refi_cnt_ff + 16'h0001;
            owed_ff     <= owed_ff + ((refi_cnt_ff >= refi_len - 16'h0001) ? 8'sh01 : 8'sh00)
                                   - (ref_launch ? 8'sh01 : 8'sh00);
        end
    end

    // ****************************************
    // Pending requests
    // ****************************************
    assign go_ref = (state_ff == S_IDLE) && tick && (ref_due || pend_ref_ff);
    assign go_zq  = (state_ff == S_IDLE) && tick && !go_ref && (pend_zql_ff || pend_zqs_ff);
    assign go_wr  = (state_ff == S_IDLE) && tick && !go_ref && !go_zq && pend_wr_ff;
    assign go_rd  = (state_ff == S_IDLE) && tick && !go_ref && !go_zq && !pend_wr_ff && pend_rd_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_ref_ff <= 1'b0;
            pend_zql_ff <= 1'b0;
            pend_zqs_ff <= 1'b0;
            pend_wr_ff  <= 1'b0;
            pend_rd_ff  <= 1'b0;
        end else begin
            // Pull-in refused once the credit limit is reached
            pend_ref_ff <= (pend_ref_ff && !go_ref && owed_ff > -max_post) ||
                           (bus_wr && avs_address == `REG_CMD && avs_writedata[`CMD_REF] &&
                            owed_ff > -max_post);
            pend_zql_ff <= (pend_zql_ff && !(go_zq && pend_zql_ff)) ||
                           (bus_wr && avs_address == `REG_CMD && avs_writedata[`CMD_ZQCL]);
            pend_zqs_ff <= (pend_zqs_ff && !(go_zq && !pend_zql_ff)) ||
                           (bus_wr && avs_address == `REG_CMD && avs_writedata[`CMD_ZQCS]);
            pend_wr_ff  <= (pend_wr_ff && !go_wr) ||
                           (bus_wr && avs_address == `REG_CMD && avs_writedata[`CMD_WR]);
            pend_rd_ff  <= (pend_rd_ff && !go_rd) ||
                           (bus_wr && avs_address == `REG_CMD && avs_writedata[`CMD_RD]);
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff        <= S_IDLE;
            cmd_ff          <= cmd_s'(`CMD_CODE_DES);
            timer_ff        <= 16'h0000;
            goal_zq_ff      <= 1'b0;
            goal_long_ff    <= 1'b0;
            zq_init_done_ff <= 1'b0;
        end else begin
            if (timer_ff != 16'h0000) begin
                timer_ff <= timer_ff - 16'h0001;
            end
            if (tick) begin
                cmd_ff <= cmd_s'(`CMD_CODE_DES);
                case (state_ff)
                    S_IDLE: begin
                        if (go_ref || go_zq) begin
                            cmd_ff       <= cmd_s'(`CMD_CODE_PREA);
                            timer_ff     <= 16'(TRP_CYC);
                            goal_zq_ff   <= go_zq;
                            goal_long_ff <= pend_zql_ff;
                            state_ff     <= S_TRP;
                        end else if (go_wr) begin
                            state_ff <= S_WR;
                        end else if (go_rd) begin
                            state_ff <= S_RD;
                        end
                    end
                    S_TRP: begin
                        if (timer_ff == 16'h0000 && goal_zq_ff) begin
                            cmd_ff   <= cmd_s'(goal_long_ff ? `CMD_CODE_ZQCL : `CMD_CODE_ZQCS);
                            timer_ff <= !goal_long_ff ? 16'(TZQS_CYC) :
                                        zq_init_done_ff ? 16'(TZQO_CYC) : 16'(TZQI_CYC);
                            state_ff <= S_TZQ;
                        end else if (timer_ff == 16'h0000) begin
                            cmd_ff   <= cmd_s'(`CMD_CODE_REF);
                            timer_ff <= 16'(TRFC_CYC);
                            state_ff <= S_TRFC;
                        end
                    end
                    S_TRFC: begin
                        if (timer_ff == 16'h0000) begin
                            state_ff <= S_IDLE;
                        end
                    end
                    S_TZQ: begin
                        if (timer_ff == 16'h0000) begin
                            zq_init_done_ff <= zq_init_done_ff || goal_long_ff;
                            state_ff        <= S_IDLE;
                        end
                    end
                    default: begin
                        state_ff <= S_IDLE;
                    end
                endcase
            end
        end
    end

    assign {cs_n, act_n, ras_n, cas_n, we_n, addr_a10} = cmd_ff;

    // ****************************************
    // Data byte and shared mask/inversion pin
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_o_ff   <= 8'h00;
            dq_oe_ff  <= 1'b0;
            dmi_o_ff  <= 1'b1;
            dmi_oe_ff <= 1'b0;
            rdata_ff  <= 8'h00;
        end else if (go_wr) begin
            dq_oe_ff  <= 1'b1;
            dmi_oe_ff <= ctrl_ff.dm || ctrl_ff.wdbi;
            if (ctrl_ff.wdbi && zeros_of(wdata_ff[7:0]) > `BYTE_ZERO_LIMIT) begin
                dq_o_ff  <= ~wdata_ff[7:0];
                dmi_o_ff <= 1'b0;
            end else begin
                dq_o_ff  <= wdata_ff[7:0];
                dmi_o_ff <= !(ctrl_ff.dm && wdata_ff[`WDATA_MASK]);
            end
        end else if (tick && state_ff == S_WR) begin
            dq_oe_ff  <= 1'b0;
            dmi_oe_ff <= 1'b0;
            dmi_o_ff  <= 1'b1;
        end else if (tick && state_ff == S_RD) begin
            rdata_ff <= (ctrl_ff.rdbi && !dmi_s2_ff) ? ~dq_s2_ff : dq_s2_ff;
        end
    end

    assign dq_o   = dq_o_ff;
    assign dq_oe  = dq_oe_ff;
    assign dmi_o  = dmi_o_ff;
    assign dmi_oe = dmi_oe_ff;

    // ****************************************
    // Assertion helpers
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            since_pre_ff <= 16'hFFFF;
            since_ref_ff <= 16'hFFFF;
        end else begin
            since_pre_ff <= (launch_ff && cmd_ff == cmd_s'(`CMD_CODE_PREA)) ? 16'h0001 :
                            (since_pre_ff == 16'hFFFF) ? since_pre_ff : since_pre_ff + 16'h0001;
            since_ref_ff <= (launch_ff && cmd_ff == cmd_s'(`CMD_CODE_REF)) ? 16'h0001 :
                            (since_ref_ff == 16'hFFFF) ? since_ref_ff : since_ref_ff + 16'h0001;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_ref_code;
        launch_ff && state_ff == S_TRFC && cmd_ff != cmd_s'(`CMD_CODE_DES)
            |-> !cs_n && !ras_n && !cas_n && we_n && act_n;
    endproperty
    a_ref_code: assert property (p_ref_code) else $error("bad refresh encoding");

    property p_ref_after_trp;
        launch_ff && cmd_ff == cmd_s'(`CMD_CODE_REF) |-> since_pre_ff >= 16'(TRP_CYC);
    endproperty
    a_ref_after_trp: assert property (p_ref_after_trp) else $error("refresh before precharge time");

    property p_trfc_quiet;
        launch_ff && cmd_ff != cmd_s'(`CMD_CODE_DES) && cmd_ff != cmd_s'(`CMD_CODE_REF)
            |-> since_ref_ff >= 16'(TRFC_CYC);
    endproperty
    a_trfc_quiet: assert property (p_trfc_quiet) else $error("command inside refresh cycle time");

    property p_postpone_max;
        owed_ff <= max_post;
    endproperty
    a_postpone_max: assert property (p_postpone_max) else $error("too many postponed refreshes");

    property p_forced_ref;
        state_ff == S_IDLE && tick && owed_ff >= max_post |=> state_ff == S_TRP;
    endproperty
    a_forced_ref: assert property (p_forced_ref) else $error("postponed limit not forced");

    property p_pullin_max;
        owed_ff >= -max_post;
    endproperty
    a_pullin_max: assert property (p_pullin_max) else $error("too many pulled-in refreshes");

    property p_dm_wdbi;
        !(ctrl_ff.dm && ctrl_ff.wdbi) && !(ctrl_ff.tdqs && (ctrl_ff.dm || ctrl_ff.rdbi));
    endproperty
    a_dm_wdbi: assert property (p_dm_wdbi) else $error("mask and inversion both on");

    property p_zq_after_trp;
        launch_ff && (cmd_ff == cmd_s'(`CMD_CODE_ZQCL) || cmd_ff == cmd_s'(`CMD_CODE_ZQCS))
            |-> since_pre_ff >= 16'(TRP_CYC);
    endproperty
    a_zq_after_trp: assert property (p_zq_after_trp) else $error("calibration before precharge time");

    property p_zq_quiet;
        state_ff == S_TZQ && launch_ff |-> cmd_ff == cmd_s'(`CMD_CODE_DES) || $past(state_ff) == S_TRP;
    endproperty
    a_zq_quiet: assert property (p_zq_quiet) else $error("command during calibration");

    property p_zq_bus;
        $rose(state_ff == S_TZQ) |-> (cke && !dq_oe && !dmi_oe) [*8];
    endproperty
    a_zq_bus: assert property (p_zq_bus) else $error("bus not released in calibration");

    c_ref:   cover property (launch_ff && cmd_ff == cmd_s'(`CMD_CODE_REF));
    c_zqcl:  cover property (launch_ff && cmd_ff == cmd_s'(`CMD_CODE_ZQCL));
    c_wdbi:  cover property (dq_oe && dmi_oe && !dmi_o);
    c_rdbi:  cover property (tick && state_ff == S_RD && ctrl_ff.rdbi && !dmi_s2_ff);

endmodule // ddr4_maint_host

// ---- tb/ddr4_dev_model.sv ----
// Behavioural device model facing the host's pins
`timescale 1ns/1ps
`include "ddr4_maint_params.svh"

module ddr4_dev_model #(
    parameter int ZQI = `T_ZQINIT_NCK,
    parameter int ZQO = `T_ZQOPER_NCK,
    parameter int ZQS = `T_ZQCS_NCK
) (
    input  wire logic       ck_t,
    input  wire logic       cke,
    input  wire logic [5:0] cmd,
    input  wire logic [7:0] dq_o,
    input  wire logic       dq_oe,
    input  wire logic       dmi_o,
    input  wire logic       dmi_oe,
    input  wire logic [2:0] en,
    input  wire logic [7:0] rd_byte,
    output logic      [7:0] dq_i,
    output logic            dmi_i,
    output logic      [7:0] mem,
    output int              n_ref,
    output int              n_zq,
    output int              n_err
);
    localparam real CK_NS = 2.0 * `CK_HALF_CYC * `CLK_PERIOD_PS / 1000.0;
    realtime t_free;
    realtime t_pre;
    logic    zq_done;
    logic    inv;
    // ****
    // Command decode and write capture
    // ****
    initial begin
        t_free = 0.0;
        t_pre = 1.0e9;
        zq_done = 1'b0;
        mem = 8'h00;
        n_ref = 0;
        n_zq = 0;
        n_err = 0;
    end
    always @(posedge ck_t) begin
        if (cmd != `CMD_CODE_DES && $realtime < t_free)
            n_err <= n_err + 1;
        if (!cke || (dq_oe && ($realtime < t_free || dmi_oe !== (en[0] || en[1]))))
            n_err <= n_err + 1;
        if (cmd == `CMD_CODE_PREA)
            t_pre = $realtime;
        if (cmd == `CMD_CODE_REF || cmd == `CMD_CODE_ZQCL || cmd == `CMD_CODE_ZQCS) begin
            if ($realtime - t_pre < `T_RP_PS / 1000.0)
                n_err <= n_err + 1;
            t_pre = 1.0e9;
        end
        if (cmd == `CMD_CODE_REF) begin
            n_ref <= n_ref + 1;
            t_free = $realtime + `T_RFC_NS;
        end
        if (cmd == `CMD_CODE_ZQCL) begin
            t_free = $realtime + CK_NS * (zq_done ? ZQO : ZQI);
            zq_done = 1'b1;
        end
        if (cmd == `CMD_CODE_ZQCS)
            t_free = $realtime + CK_NS * ZQS;
        if (cmd == `CMD_CODE_ZQCL || cmd == `CMD_CODE_ZQCS)
            n_zq <= n_zq + 1;
        if (dq_oe && !(en[0] && !dmi_o))
            mem <= (en[1] && !dmi_o) ? ~dq_o : dq_o;
    end
    // ****
    // Read drive
    // ****
    assign inv = en[2] && ($countones(~rd_byte) > 4);
    assign dq_i = inv ? ~rd_byte : rd_byte;
    assign dmi_i = en[2] ? ~inv : 1'b0;
endmodule // ddr4_dev_model

// ---- tb/tb_ddr4_maint_host.sv ----
// Self-checking bench for the DDR4 maintenance host
`timescale 1ns/1ps
`include "ddr4_maint_params.svh"

module tb_ddr4_maint_host import ddr4_maint_pkg::*;;
    typedef struct packed {logic [7:0] ctrl; logic [4:0] cmd; logic [8:0] val; logic [7:0] exp;} row_s;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        wait_q;
    logic        ck_t;
    cmd_s        cmd;
    logic [7:0]  dq_o;
    logic [7:0]  dq_i;
    logic [7:0]  mem;
    logic [7:0]  rd_byte = 8'h00;
    logic [2:0]  en = 3'h0;
    logic        dq_oe;
    logic        dmi_o;
    logic        dmi_i;
    logic        cke;
    logic        dmi_oe;
    int          n_ref;
    int          n_zq;
    int          n_err;
    int          r0;
    int          n_fail = 0;
    int          samples_checked = 0;
    row_s rows [9] = '{{8'h00,5'h08,9'h05A,8'h5A}, {8'h04,5'h08,9'h1A5,8'h5A}, {8'h04,5'h08,9'h0C3,8'hC3},
        {8'h08,5'h08,9'h003,8'h03}, {8'h08,5'h08,9'h0F7,8'hF7}, {8'h10,5'h10,9'h001,8'h01},
        {8'h10,5'h10,9'h0EF,8'hEF}, {8'h00,5'h10,9'h011,8'h11}, {8'h30,5'h10,9'h000,8'h00}};

    ddr4_maint_host #(.TZQINIT_NCK(16), .TZQOPER_NCK(8), .TZQCS_NCK(4)) dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_readdata(rdata), .avs_waitrequest(wait_q), .ck_t(ck_t), .ck_c(), .cke(cke), .cs_n(cmd.cs_n),
        .act_n(cmd.act_n), .ras_n(cmd.ras_n), .cas_n(cmd.cas_n), .we_n(cmd.we_n), .addr_a10(cmd.a10),
        .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dmi_i(dmi_i), .dmi_o(dmi_o), .dmi_oe(dmi_oe));
    ddr4_dev_model #(.ZQI(16), .ZQO(8), .ZQS(4)) dev (.ck_t(ck_t), .cke(cke), .cmd(cmd), .dq_o(dq_o),
        .dq_oe(dq_oe), .dmi_o(dmi_o), .dmi_oe(dmi_oe), .en(en), .rd_byte(rd_byte), .dq_i(dq_i),
        .dmi_i(dmi_i), .mem(mem), .n_ref(n_ref), .n_zq(n_zq), .n_err(n_err));
    // ****
    // Tasks
    // ****
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do @(posedge sys_clk); while (wait_q !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic idle();
        repeat (8) @(posedge sys_clk);
        do bus(1'b0, `REG_STATUS, 32'h0); while (q[`STAT_BUSY] !== 1'b0);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****
    // Clock, watchdog and tests
    // ****
    initial forever #2.5 sys_clk = ~sys_clk;
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("status", 32'h0, q);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        r0 = n_ref;
        bus(1'b1, `REG_CMD, 32'h1);
        bus(1'b1, `REG_CMD, 32'h4);
        idle();
        chk("ref", 32'(r0 + 1), 32'(n_ref));
        chk("owed", 32'hFF, 32'(q[15:8]));
        $display("test refresh done");
        foreach (rows[i]) begin
            en <= rows[i].ctrl[5] ? 3'h0 : rows[i].ctrl[4:2];
            rd_byte <= rows[i].val[7:0];
            bus(1'b1, `REG_CTRL, 32'(rows[i].ctrl));
            bus(1'b1, `REG_WDATA, 32'(rows[i].val));
            bus(1'b1, `REG_CMD, 32'(rows[i].cmd));
            idle();
            bus(1'b0, `REG_RDATA, 32'h0);
            chk("data", 32'(rows[i].exp), rows[i].cmd[`CMD_WR] ? 32'(mem) : q);
        end
        $display("test rows done");
        bus(1'b1, `REG_CMD, 32'h2);
        idle();
        chk("zqinit", 32'h1, 32'(q[`STAT_ZQINIT]));
        chk("zq", 32'h2, 32'(n_zq));
        $display("test calibration done");
        reset_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("reset", 32'h0, q);
        r0 = n_ref;
        bus(1'b1, `REG_CMD, 32'h1);
        repeat (3200) @(posedge sys_clk);
        idle();
        chk("refi", 32'(r0 + 2), 32'(n_ref));
        chk("credit", 32'h0, 32'(q[15:8]));
        chk("gaps", 32'h0, 32'(n_err));
        $display("test reset and interval done");
        end_sim();
    end
endmodule // tb_ddr4_maint_host
